// *** rtl/aeb_top.sv ***
// external bus sequencer for asynchronous memories, with apb registers
//
// Contract
// [R1] separate mode bare cycle is three clocks
// [R2] all phases counted in system clocks
// [R3] separate internal access: pins hold, strobes idle
// [R4] multiplexed mode bare cycle is four clocks; the code takes three with a one-clock latch phase
// [R5] multiplexed internal access: no latch pulse, idle
// [R6] strobe extended by zero to 15 wait clocks
// [R7] read/write recovery: none, one-six, eight clocks
// [R8] select recovery: none, one, two, four clocks
// [R9] setup before strobe up to four clocks
// [R10] latch phase 1, 2 or 4 clocks
// [R11] default strobe two clocks after address
// [R12] register block decoded at fixed offsets
// [R13] software uses word accesses only
// [R14] software avoids reserved offsets
// [R15] mode bits 31:3 read zero
// [R16] extension scales counts by one, two, four
// [R17] mode bit 0 multiplexed, 1 separate
// [R18] overlapping windows: channel zero wins
// [R19] window start and size compare upper bits
// [R20] setup, strobe plus wait, then recoveries
// [R21] matched channel gives timing and select
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module aeb_top (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  output logic REQ_DONE,
  output logic [15:0] REQ_RDATA,
  output logic [23:0] EXT_ADDR,
  output logic [15:0] EXT_DATA_OUT,
  output logic EXT_DATA_OE,
  input wire logic [15:0] EXT_DATA_IN,
  output logic EXT_RD_N,
  output logic EXT_WR_N,
  output logic EXT_CHIP_SELECT_ZERO_N,
  output logic EXT_CHIP_SELECT_ONE_N,
  output logic EXT_ALE
);
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0][31:0] area;
    logic [1:0][31:0] tim;
    aeb_pkg::aeb_state_t state;
    logic [7:0] cnt;
    logic ch;
    logic wr;
    logic mux;
    logic [1:0] ext;
    logic [15:0] wdata;
    logic done;
    logic [15:0] rdata;
    logic [23:0] addr;
    logic [15:0] dout;
    logic oe;
    logic rd_n;
    logic wr_n;
    logic [1:0] cs_n;
    logic ale;
    logic [1:0] last_cs;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } aeb_regs_t;

  aeb_regs_t s_reg;
  aeb_regs_t s_next;
  aeb_tim_if tif ();

  aeb_cycle_calc u_calc (
    .t(tif.calc)
  );

  // window hit: top size-code bits of a[23:16] must equal the start field
  function automatic logic aeb_hit(input logic [31:0] area, input logic [31:0] adr);
    logic [7:0] size;
    logic [7:0] mask;
    size = area[aeb_pkg::AREA_SIZE_LSB +: 8];
    mask = ~(8'hFF >> size[3:0]);
    return (size <= aeb_pkg::SIZE_MAX) &&
      ((adr[23:16] & mask) == (area[aeb_pkg::AREA_START_LSB +: 8] & mask)); // [R19]
  endfunction

  logic in_win;
  logic hit0;
  logic hit1;
  logic dec_ch;
  logic start_ext;
  logic start_int;
  logic apb_hit;
  logic [31:0] rd_word;
  logic rd_ok;

  // address decode of the incoming request
  always_comb
  begin
    in_win = (REQ_ADDR[aeb_pkg::WIN_TAG_LSB +: 7] == aeb_pkg::EXT_WIN_TAG);
    hit0 = in_win && aeb_hit(s_reg.area[0], REQ_ADDR);
    hit1 = in_win && aeb_hit(s_reg.area[1], REQ_ADDR);
    dec_ch = !hit0 && hit1; // [R18]
    start_ext = (s_reg.state == aeb_pkg::ST_IDLE) && REQ_VALID && !s_reg.done &&
      (hit0 || hit1);
    // unmatched addresses complete with the pins untouched
    start_int = (s_reg.state == aeb_pkg::ST_IDLE) && REQ_VALID && !s_reg.done &&
      !(hit0 || hit1);
  end

  // timing word of the matched channel; channel, direction and extension frozen once the cycle runs
  always_comb
  begin
    tif.tim_word = (s_reg.state == aeb_pkg::ST_IDLE) ? s_reg.tim[dec_ch]
                                                     : s_reg.tim[s_reg.ch]; // [R21]
    tif.ext_code = (s_reg.state == aeb_pkg::ST_IDLE) ?
      s_reg.mode[aeb_pkg::MODE_EXT_LSB +: 2] : s_reg.ext;
    tif.is_write = (s_reg.state == aeb_pkg::ST_IDLE) ? REQ_WRITE : s_reg.wr;
  end

  // apb read mux; unmapped offsets answer with an error
  always_comb
  begin
    apb_hit = (PADDR[31:12] == aeb_pkg::BASE_ADDR[31:12]) && (PADDR[1:0] == 2'b00);
    rd_ok = apb_hit;
    rd_word = 32'h0000_0000;
    unique case (PADDR[11:0])
      aeb_pkg::OFS_MODE: rd_word = {29'h0000_0000, s_reg.mode}; // [R15]
      aeb_pkg::OFS_AREA0: rd_word = s_reg.area[0];
      aeb_pkg::OFS_AREA1: rd_word = s_reg.area[1];
      aeb_pkg::OFS_TIM0: rd_word = s_reg.tim[0];
      aeb_pkg::OFS_TIM1: rd_word = s_reg.tim[1];
      aeb_pkg::OFS_STAT: rd_word = {28'h000_0000, s_reg.last_cs, 1'b0,
        (s_reg.state != aeb_pkg::ST_IDLE)};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    // apb: one wait cycle, write lands on the edge that sees pready high
    s_next.pready = PSEL && PENABLE && !s_reg.pready;
    if (PSEL && PENABLE && !s_reg.pready)
    begin
      s_next.prdata = PWRITE ? 32'h0000_0000 : rd_word;
      s_next.pslverr = !rd_ok;
    end
    if (PSEL && PENABLE && s_reg.pready && PWRITE && rd_ok)
    begin
      unique case (PADDR[11:0]) // [R12]
        aeb_pkg::OFS_MODE: s_next.mode = PWDATA[2:0] & aeb_pkg::MODE_MASK[2:0]; // [R15]
        aeb_pkg::OFS_AREA0: s_next.area[0] = PWDATA & aeb_pkg::AREA_MASK;
        aeb_pkg::OFS_AREA1: s_next.area[1] = PWDATA & aeb_pkg::AREA_MASK;
        aeb_pkg::OFS_TIM0: s_next.tim[0] = PWDATA & aeb_pkg::TIM_MASK;
        aeb_pkg::OFS_TIM1: s_next.tim[1] = PWDATA & aeb_pkg::TIM_MASK;
        default: s_next.mode = s_reg.mode;
      endcase
    end

    // bus sequencer, counted in system clocks throughout
    unique case (s_reg.state) // [R2]
      aeb_pkg::ST_IDLE:
      begin
        if (start_int)
          s_next.done = 1'b1; // [R3] [R5]
        if (start_ext)
        begin
          s_next.ch = dec_ch; // [R18]
          s_next.wr = REQ_WRITE;
          // mode is sampled per access so a stray change cannot tear a cycle
          s_next.mux = !s_reg.mode[aeb_pkg::MODE_SEL_BIT]; // [R17]
          s_next.ext = s_reg.mode[aeb_pkg::MODE_EXT_LSB +: 2];
          s_next.addr = REQ_ADDR[23:0];
          s_next.wdata = REQ_WDATA;
          s_next.state = aeb_pkg::ST_ADDR;
          // latch phase in multiplexed mode, one address clock otherwise
          s_next.cnt = s_reg.mode[aeb_pkg::MODE_SEL_BIT] ?
            aeb_pkg::SEP_ADDR_CYC - 8'h01 : tif.lat_cnt - 8'h01; // [R1] [R4] [R10] [R11]
        end
      end
      aeb_pkg::ST_ADDR:
      begin
        if (s_reg.cnt != 8'h00)
          s_next.cnt = s_reg.cnt - 8'h01;
        else if (tif.setup_cnt != 8'h00)
        begin
          s_next.state = aeb_pkg::ST_SETUP; // [R9] [R20]
          s_next.cnt = tif.setup_cnt - 8'h01;
        end
        else
        begin
          s_next.state = aeb_pkg::ST_STROBE;
          s_next.cnt = tif.wait_cnt; // [R6]
        end
      end
      aeb_pkg::ST_SETUP:
      begin
        if (s_reg.cnt != 8'h00)
          s_next.cnt = s_reg.cnt - 8'h01;
        else
        begin
          s_next.state = aeb_pkg::ST_STROBE;
          s_next.cnt = tif.wait_cnt; // [R6] [R20]
        end
      end
      aeb_pkg::ST_STROBE:
      begin
        if (s_reg.cnt != 8'h00)
          s_next.cnt = s_reg.cnt - 8'h01;
        else
        begin
          // sample read data on the last strobe clock
          if (!s_reg.wr)
            s_next.rdata = EXT_DATA_IN;
          s_next.state = aeb_pkg::ST_HOLD;
          s_next.cnt = aeb_pkg::HOLD_CYC - 8'h01;
        end
      end
      aeb_pkg::ST_HOLD:
      begin
        s_next.done = 1'b1;
        if (tif.rec_cnt != 8'h00)
        begin
          s_next.state = aeb_pkg::ST_RECOV; // [R7] [R8] [R20]
          s_next.cnt = tif.rec_cnt - 8'h01;
        end
        else
          s_next.state = aeb_pkg::ST_IDLE;
      end
      aeb_pkg::ST_RECOV:
      begin
        if (s_reg.cnt != 8'h00)
          s_next.cnt = s_reg.cnt - 8'h01;
        else
          s_next.state = aeb_pkg::ST_IDLE; // [R20]
      end
      default: s_next.state = aeb_pkg::ST_IDLE;
    endcase

    // pin levels follow the next state so they leave flops directly
    s_next.ale = s_next.mux && (s_next.state == aeb_pkg::ST_ADDR); // [R5] [R10]
    s_next.rd_n = !((s_next.state == aeb_pkg::ST_STROBE) && !s_next.wr); // [R3]
    s_next.wr_n = !((s_next.state == aeb_pkg::ST_STROBE) && s_next.wr);
    s_next.cs_n = 2'b11;
    if ((s_next.state != aeb_pkg::ST_IDLE) && (s_next.state != aeb_pkg::ST_RECOV))
      s_next.cs_n[s_next.ch] = 1'b0; // [R21]
    if (s_next.state != aeb_pkg::ST_IDLE)
      s_next.last_cs = ~s_next.cs_n;
    // shared lines carry the address during the latch phase
    if (s_next.mux && (s_next.state == aeb_pkg::ST_ADDR))
    begin
      s_next.oe = 1'b1; // [R4]
      s_next.dout = s_next.addr[15:0];
    end
    else
    begin
      s_next.oe = s_next.wr && ((s_next.state == aeb_pkg::ST_SETUP) ||
        (s_next.state == aeb_pkg::ST_STROBE) || (s_next.state == aeb_pkg::ST_HOLD) ||
        (!s_next.mux && (s_next.state == aeb_pkg::ST_ADDR)));
      s_next.dout = s_next.wdata;
    end
    // data floats whenever no external cycle drives it
    if (s_next.state == aeb_pkg::ST_IDLE || s_next.state == aeb_pkg::ST_RECOV)
      s_next.oe = 1'b0; // [R3] [R5]
  end

  // single state register; the address is held across internal accesses
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      s_reg <= '0;
      s_reg.mode <= aeb_pkg::MODE_RST[2:0];
      s_reg.area <= {aeb_pkg::AREA_RST, aeb_pkg::AREA_RST};
      s_reg.tim <= {aeb_pkg::TIM_RST, aeb_pkg::TIM_RST}; // [R11]
      s_reg.state <= aeb_pkg::ST_IDLE;
      s_reg.rd_n <= 1'b1;
      s_reg.wr_n <= 1'b1;
      s_reg.cs_n <= 2'b11;
    end
    else
      s_reg <= s_next;
  end

  assign PRDATA = s_reg.prdata;
  assign PREADY = s_reg.pready;
  assign PSLVERR = s_reg.pslverr;
  assign REQ_DONE = s_reg.done;
  assign REQ_RDATA = s_reg.rdata;
  assign EXT_ADDR = s_reg.addr;
  assign EXT_DATA_OUT = s_reg.dout;
  assign EXT_DATA_OE = s_reg.oe;
  assign EXT_RD_N = s_reg.rd_n;
  assign EXT_WR_N = s_reg.wr_n;
  assign EXT_CHIP_SELECT_ZERO_N = s_reg.cs_n[0];
  assign EXT_CHIP_SELECT_ONE_N = s_reg.cs_n[1];
  assign EXT_ALE = s_reg.ale;
endmodule

// *** rtl/aeb_pkg.sv ***
// constants, field layout and state codes of the external bus sequencer
package aeb_pkg;
  // register block placement and word offsets
  localparam logic [31:0] BASE_ADDR = 32'h4005_C000;
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_AREA0 = 12'h010;
  localparam logic [11:0] OFS_AREA1 = 12'h014;
  localparam logic [11:0] OFS_TIM0 = 12'h040;
  localparam logic [11:0] OFS_TIM1 = 12'h044;
  localparam logic [11:0] OFS_STAT = 12'hFF0;
  // bus mode control fields
  localparam int MODE_SEL_BIT = 0;
  localparam int MODE_EXT_LSB = 1;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_MASK = 32'h0000_0007;
  // area and start fields
  localparam int AREA_SIZE_LSB = 0;
  localparam int AREA_START_LSB = 16;
  localparam logic [31:0] AREA_RST = 32'h0000_0000;
  localparam logic [31:0] AREA_MASK = 32'hFFFF_00FF;
  localparam logic [7:0] SIZE_MAX = 8'h08;
  // chip-select timing fields
  localparam int TIM_WAIT_LSB = 0;
  localparam int TIM_RDS_LSB = 16;
  localparam int TIM_WRS_LSB = 18;
  localparam int TIM_LAT_LSB = 20;
  localparam int TIM_RDR_LSB = 24;
  localparam int TIM_WRR_LSB = 27;
  localparam int TIM_CSR_LSB = 30;
  localparam logic [31:0] TIM_RST = 32'h4911_0000;
  localparam logic [31:0] TIM_MASK = 32'hFF3F_001F;
  // external window: address bits 31:25
  localparam logic [6:0] EXT_WIN_TAG = 7'h30;
  localparam int WIN_TAG_LSB = 25;
  // cycle figures that are fixed by the bus structure
  localparam logic [7:0] SEP_ADDR_CYC = 8'h01;
  localparam logic [7:0] HOLD_CYC = 8'h01;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b100,
    ST_RECOV = 3'b101
  } aeb_state_t;
endpackage

// *** rtl/aeb_tim_if.sv ***
// carrier between the sequencer and its cycle-count calculator
`timescale 1ns/1ps
interface aeb_tim_if;
  logic [31:0] tim_word;
  logic [1:0] ext_code;
  logic is_write;
  logic [7:0] lat_cnt;
  logic [7:0] setup_cnt;
  logic [7:0] wait_cnt;
  logic [7:0] rec_cnt;
  modport seq (output tim_word, output ext_code, output is_write,
    input lat_cnt, input setup_cnt, input wait_cnt, input rec_cnt);
  modport calc (input tim_word, input ext_code, input is_write,
    output lat_cnt, output setup_cnt, output wait_cnt, output rec_cnt);
endinterface

// *** rtl/aeb_cycle_calc.sv ***
// turns a channel timing word and the extension code into cycle counts
`timescale 1ns/1ps
module aeb_cycle_calc (
  aeb_tim_if.calc t
);
  // scale by 1, 2 or 4; the prohibited code falls back to no scaling
  function automatic logic [7:0] aeb_scale(input logic [7:0] v, input logic [1:0] e);
    logic [7:0] r;
    r = v;
    if (e == 2'b01)
      r = {v[6:0], 1'b0};
    else if (e == 2'b10)
      r = {v[5:0], 2'b00};
    return r;
  endfunction

  // two-bit code to 0, 1, 2 or 4
  function automatic logic [7:0] aeb_quad(input logic [1:0] c);
    logic [7:0] r;
    r = (c == 2'b11) ? 8'h04 : {6'h00, c};
    return r;
  endfunction

  logic [2:0] rec_code;
  logic [7:0] rw_rec;
  logic [1:0] lat_code;

  always_comb
  begin
    rec_code = t.is_write ? t.tim_word[aeb_pkg::TIM_WRR_LSB +: 3]
                          : t.tim_word[aeb_pkg::TIM_RDR_LSB +: 3];
    rw_rec = (rec_code == 3'b111) ? 8'h08 : {5'h00, rec_code}; // [R7]
    lat_code = t.tim_word[aeb_pkg::TIM_LAT_LSB +: 2];
    // latch phase 1, 2 or 4; code 11 read as 4
    t.lat_cnt = aeb_scale((lat_code == 2'b00) ? 8'h01 :
                          (lat_code == 2'b01) ? 8'h02 : 8'h04, t.ext_code); // [R10] [R16]
    t.setup_cnt = aeb_scale(aeb_quad(t.is_write ? t.tim_word[aeb_pkg::TIM_WRS_LSB +: 2]
                                                : t.tim_word[aeb_pkg::TIM_RDS_LSB +: 2]),
                            t.ext_code); // [R9] [R16]
    t.wait_cnt = aeb_scale({4'h0, t.tim_word[aeb_pkg::TIM_WAIT_LSB +: 4]}, t.ext_code); // [R6]
    // largest sum is 8 x 4 + 4 x 4, so the cut to eight bits loses nothing
    t.rec_cnt = 8'(aeb_scale(rw_rec, t.ext_code) +
                aeb_scale(aeb_quad(t.tim_word[aeb_pkg::TIM_CSR_LSB +: 2]), t.ext_code)); // [R8]
  end
endmodule

// *** tb/aeb_mem_model.sv ***
// asynchronous sram model on the far side of the external bus
`timescale 1ns/1ps
module aeb_mem_model (
  input wire logic clk,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cs_n,
  output logic [15:0] rdata
);
  logic [15:0] mem [16];
  logic [15:0] last;
  initial
  begin
    last = 16'h0000;
    for (int i = 0; i < 16; i++)
      mem[i] = 16'h5A00 ^ 16'(i);
  end
  // write lands at the trailing strobe edge, select still low in hold
  always @(posedge wr_n)
    if (!cs_n)
      mem[addr[3:0]] <= wdata;
  // remember what was driven so a released bus shows its inverse
  always @(posedge clk)
    if (!rd_n && !cs_n)
      last <= mem[addr[3:0]];
  // undriven lines have no pull: show inverse, never a stale copy
  assign rdata = (!rd_n && !cs_n) ? mem[addr[3:0]] : ~last;
endmodule

// *** tb/aeb_top_props.sv ***
// port-level assertions on the external bus sequencer
`timescale 1ns/1ps
module aeb_props (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic REQ_DONE,
  input wire logic EXT_DATA_OE,
  input wire logic EXT_RD_N,
  input wire logic EXT_WR_N,
  input wire logic EXT_CHIP_SELECT_ZERO_N,
  input wire logic EXT_CHIP_SELECT_ONE_N,
  input wire logic EXT_ALE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic [7:0] rd_low_reg;
  // length of the current read strobe, longest is 1 + 15 x 4
  always_ff @(posedge SYS_CLK)
  begin
    if (RST || EXT_RD_N)
      rd_low_reg <= 8'h00;
    else
      rd_low_reg <= rd_low_reg + 8'h01;
  end
  sequence s_rd_end;
    $rose(EXT_RD_N);
  endsequence
  sequence s_wr_end;
    $rose(EXT_WR_N);
  endsequence
  a_strobe_excl: assert property (EXT_RD_N || EXT_WR_N)
    else $error("both strobes low");
  a_one_select: assert property (EXT_CHIP_SELECT_ZERO_N || EXT_CHIP_SELECT_ONE_N)
    else $error("both selects low");
  a_strobe_has_select: assert property (!(EXT_RD_N && EXT_WR_N) |->
    !(EXT_CHIP_SELECT_ZERO_N && EXT_CHIP_SELECT_ONE_N))
    else $error("strobe without select");
  a_read_floats: assert property (!EXT_RD_N |-> !EXT_DATA_OE)
    else $error("data driven during read");
  a_latch_idle: assert property (EXT_ALE |-> EXT_RD_N && EXT_WR_N && EXT_DATA_OE)
    else $error("latch phase not clean");
  a_apb_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("apb answer timing");
  a_mode_upper_zero: assert property (PREADY && !PWRITE && PADDR == aeb_pkg::BASE_ADDR
    |-> PRDATA[31:3] == 29'h0000_0000)
    else $error("mode upper bits set");
  a_read_then_done: assert property (s_rd_end |=> REQ_DONE)
    else $error("no done after read");
  a_write_then_done: assert property (s_wr_end |=> REQ_DONE)
    else $error("no done after write");
  a_wait_bound: assert property (rd_low_reg <= 8'h3D)
    else $error("read strobe too long");
  a_done_pulse: assert property (REQ_DONE |=> !REQ_DONE)
    else $error("done longer than a clock");
endmodule
bind aeb_top aeb_props u_props (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .REQ_DONE(REQ_DONE), .EXT_DATA_OE(EXT_DATA_OE), .EXT_RD_N(EXT_RD_N), .EXT_WR_N(EXT_WR_N),
  .EXT_CHIP_SELECT_ZERO_N(EXT_CHIP_SELECT_ZERO_N),
  .EXT_CHIP_SELECT_ONE_N(EXT_CHIP_SELECT_ONE_N), .EXT_ALE(EXT_ALE));

// *** tb/tb_async_external_bus_interface.sv ***
// self-checking bench for the external bus sequencer
`timescale 1ns/1ps
module tb_async_external_bus_interface;
  logic clk, rst, psel, pen, pwr, pready, pslverr, rq_v, rq_w, done, oe, rd_n, wr_n;
  logic cs0_n, cs1_n, ale;
  logic [31:0] paddr, pwdata, prdata, rq_a, rv;
  logic [15:0] rq_wd, rq_rd, dout, din;
  logic [23:0] ea;
  int num_errors, samples_checked, n_cyc, n_cs, n_c1, n_rd, n_ale, n_oe, n0;
  aeb_top dut_u (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .REQ_VALID(rq_v), .REQ_WRITE(rq_w), .REQ_ADDR(rq_a), .REQ_WDATA(rq_wd), .REQ_DONE(done),
    .REQ_RDATA(rq_rd), .EXT_ADDR(ea), .EXT_DATA_OUT(dout), .EXT_DATA_OE(oe),
    .EXT_DATA_IN(din), .EXT_RD_N(rd_n), .EXT_WR_N(wr_n), .EXT_CHIP_SELECT_ZERO_N(cs0_n),
    .EXT_CHIP_SELECT_ONE_N(cs1_n), .EXT_ALE(ale));
  aeb_mem_model mem_u (.clk(clk), .addr(ea), .wdata(dout), .rd_n(rd_n), .wr_n(wr_n),
    .cs_n(cs0_n & cs1_n), .rdata(din));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // apb master: word accesses only, held until pready is seen, then released
  task automatic apb(input logic w, input logic [11:0] o, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwr <= w; paddr <= aeb_pkg::BASE_ADDR | {20'h0_0000, o}; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    // a slave that never answers counts as a mismatch
    if (pready !== 1'b1)
      num_errors++;
    rv = prdata;
    chk("apb error", {31'h0000_0000, pslverr}, {31'h0000_0000, o == 12'h004});
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // cnt requests kept back to back; counts describe the last one
  task automatic acc(input logic w, input logic [31:0] a, input int cnt);
    rq_v <= 1'b1; rq_w <= w; rq_a <= a; rq_wd <= ~a[15:0];
    repeat (cnt)
    begin
      n_cyc = 0; n_cs = 0; n_c1 = 0; n_rd = 0; n_ale = 0; n_oe = 0;
      do
      begin
        @(posedge clk);
        n_cyc++;
        n_cs += (cs0_n === 1'b0); n_c1 += (cs1_n === 1'b0); n_oe += (oe === 1'b1);
        n_rd += (rd_n === 1'b0 || wr_n === 1'b0); n_ale += (ale === 1'b1);
      end
      while (done !== 1'b1 && n_cyc < 300);
      if (n_cyc >= 300)
        num_errors++;
    end
    rq_v <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_regs();
    apb(0, aeb_pkg::OFS_MODE, 0); chk("mode reset", rv, 32'h0000_0000);
    apb(0, aeb_pkg::OFS_TIM0, 0); chk("timing reset", rv, 32'h4911_0000);
    apb(0, aeb_pkg::OFS_AREA1, 0); chk("area reset", rv, 32'h0000_0000);
    apb(1, aeb_pkg::OFS_MODE, 32'hFFFF_FFFF);
    apb(0, aeb_pkg::OFS_MODE, 0); chk("mode mask", rv, 32'h0000_0007);
    apb(0, 12'h004, 0); chk("reserved read", rv, 32'h0000_0000);
  endtask
  task automatic t_sep();
    apb(1, aeb_pkg::OFS_MODE, 32'h0000_0001);
    apb(1, aeb_pkg::OFS_TIM0, 32'h0000_0000);
    apb(1, aeb_pkg::OFS_AREA0, 32'h6000_0000);
    apb(1, aeb_pkg::OFS_AREA1, 32'h6000_0009);
    acc(1, 32'h6000_0005, 1); chk("write cycle", n_cs, 3);
    acc(0, 32'h6000_0005, 1); chk("read cycle", n_cs, 3);
    chk("read data", rq_rd, 16'hFFFA);
    acc(0, 32'h2000_0000, 1); chk("int strobes", n_cs + n_rd + n_oe, 0);
    chk("int addr", ea, 24'h00_0005);
    apb(1, aeb_pkg::OFS_TIM0, 32'h0002_0000);
    acc(0, 32'h6000_0005, 1); chk("setup cycles", n_cs, 5);
    for (int k = 0; k < 3; k++)
    begin
      apb(1, aeb_pkg::OFS_MODE, 32'(2 * k + 1));
      apb(1, aeb_pkg::OFS_TIM0, 32'h0000_0003);
      acc(0, 32'h6000_0001, 1); chk("wait strobe", n_rd, 1 + 3 * (1 << k));
    end
  endtask
  task automatic t_mux();
    apb(1, aeb_pkg::OFS_MODE, 32'h0000_0000);
    for (int c = 0; c < 3; c++)
    begin
      apb(1, aeb_pkg::OFS_TIM0, 32'(c) << 20);
      acc(0, 32'h6000_0002, 1); chk("latch width", n_ale, 1 << c);
      chk("mux cycle", n_cs, (1 << c) + 2);
    end
    acc(0, 32'h2000_0000, 1); chk("int latch", n_ale + n_cs + n_oe, 0);
  endtask
  task automatic t_rec();
    apb(1, aeb_pkg::OFS_MODE, 32'h0000_0001);
    apb(1, aeb_pkg::OFS_TIM0, 32'h0000_0000);
    acc(0, 32'h6000_0003, 2); n0 = n_cyc;
    apb(1, aeb_pkg::OFS_TIM0, 32'h8300_0000);
    // the idle clock after done overlaps the first recovery clock, so one less shows
    acc(0, 32'h6000_0003, 2); chk("read recovery", n_cyc - n0, 5 - 1);
    apb(1, aeb_pkg::OFS_TIM0, 32'h0000_0000);
    acc(1, 32'h6000_0003, 2); n0 = n_cyc;
    apb(1, aeb_pkg::OFS_TIM0, 32'h3800_0000);
    acc(1, 32'h6000_0003, 2); chk("write recovery", n_cyc - n0, 8 - 1);
  endtask
  task automatic t_chan();
    apb(1, aeb_pkg::OFS_TIM0, 32'h0000_0000);
    apb(1, aeb_pkg::OFS_TIM1, 32'h0000_0002);
    apb(1, aeb_pkg::OFS_AREA1, 32'h6000_0000);
    acc(0, 32'h6010_0000, 1); chk("overlap cs1", n_c1, 0);
    apb(1, aeb_pkg::OFS_AREA0, 32'h6010_0008);
    acc(0, 32'h6010_0000, 1); chk("window cs0", n_c1 == 0 && n_cs == 3, 1);
    acc(0, 32'h6020_0000, 1); chk("window cs1", n_cs == 0 && n_c1 == 5, 1);
    chk("cs1 wait", n_rd, 3);
    // status keeps the select pair of the last cycle in bits 3:2 when no recovery phase follows (recovery clears it), idle now
    apb(0, aeb_pkg::OFS_STAT, 0); chk("last select", rv, 32'h0000_0008);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // stop a hang well past the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000; rq_v = 1'b0; rq_w = 1'b0; rq_a = 32'h0000_0000;
    rq_wd = 16'h0000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_sep();
    t_mux();
    t_rec();
    t_chan();
    wrap_up();
  end
endmodule
